// ===== core/crtp_pkg.sv
// Shared constants for the indexed register port
`default_nettype none
package crtp_pkg;
	// ---------------------------------------------
	// Sizes
	// ---------------------------------------------
	localparam int unsigned CRTP_ADDR_W = 14;
	localparam int unsigned CRTP_IDX_W = 5;
	localparam int unsigned CRTP_NUM_CTRL = 16;
	localparam int unsigned CRTP_NUM_TIMING = 12;
	// ---------------------------------------------
	// Register indices
	// ---------------------------------------------
	localparam logic [4:0] CRTP_IDX_START_HI = 5'h0C;
	localparam logic [4:0] CRTP_IDX_START_LO = 5'h0D;
	localparam logic [4:0] CRTP_IDX_CURSOR_HI = 5'h0E;
	localparam logic [4:0] CRTP_IDX_CURSOR_LO = 5'h0F;
	localparam logic [4:0] CRTP_IDX_PEN_HI = 5'h10;
	localparam logic [4:0] CRTP_IDX_PEN_LO = 5'h11;
	localparam logic [4:0] CRTP_IDX_LIMIT = 5'h12;
	// ---------------------------------------------
	// Reset values
	// ---------------------------------------------
	localparam logic [7:0] CRTP_REG_RST = 8'h00;
	localparam logic [4:0] CRTP_IDX_RST = 5'h00;
	localparam logic [7:0] CRTP_RDATA_RST = 8'h00;
	typedef logic [7:0] crtp_byte_t;
endpackage
`default_nettype wire

// ===== core/crtp_pen_if.sv
// Signals between the register port and the pen capture unit
`default_nettype none
interface crtp_pen_if #(
	parameter int unsigned ADDR_W = 14
);
	logic [ADDR_W-1:0] refresh_addr;
	logic [ADDR_W-1:0] pen_addr;
	logic pen_flag;
	logic pen_read;
	modport port (output refresh_addr, output pen_read, input pen_addr, input pen_flag);
	modport capture (input refresh_addr, input pen_read, output pen_addr, output pen_flag);
endinterface
`default_nettype wire

// ===== core/crtp_pen_capture.sv
// Light pen strobe synchroniser and address capture
`default_nettype none
module crtp_pen_capture
	import crtp_pkg::*;
#(
	parameter int unsigned ADDR_W = CRTP_ADDR_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Pen strobe, asynchronous
	input wire logic pen_capture_strobe_i,
	// Toward the register port
	crtp_pen_if.capture pen
);
	logic sync_meta;
	logic sync_q;
	logic sync_last;
	logic [ADDR_W-1:0] pen_addr;
	logic pen_flag;
	wire pen_edge = sync_q && !sync_last;

	// ---------------------------------------------
	// Synchroniser and capture
	// ---------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sync_meta <= 1'b0;
			sync_q <= 1'b0;
			sync_last <= 1'b0;
		end else begin
			sync_meta <= pen_capture_strobe_i;
			sync_q <= sync_meta;
			sync_last <= sync_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pen_addr <= '0;
			pen_flag <= 1'b0;
		end else begin
			if (pen_edge) begin
				pen_addr <= pen.refresh_addr;
			end
			pen_flag <= pen_edge || (pen_flag && !pen.pen_read);
		end
	end

	assign pen.pen_addr = pen_addr;
	assign pen.pen_flag = pen_flag;

	// ---------------------------------------------
	// Checks
	// ---------------------------------------------
	sequence s_pen_rise;
		!sync_q ##1 sync_q;
	endsequence

	property p_pen_capture;
		@(posedge clk_i) disable iff (reset_i)
		s_pen_rise |=> (pen_addr == $past(pen.refresh_addr)) && pen_flag;
	endproperty

	AST_PEN_CAPTURE: assert property (p_pen_capture)
		else $error("pen address not captured on strobe");

	AST_PEN_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
		!pen_edge |=> $stable(pen_addr))
		else $error("pen address changed without strobe");
endmodule
`default_nettype wire

// ===== core/crtp_register_port.sv
// Indexed register port of the raster timing controller
// What this block does
// - Eighteen indexed registers plus one index register
// - Select low reaches the index register
// - Select high reaches the indexed register
// - Cursor marker held low outside displayed addresses
// - Any base address value is accepted
// - Pen capture shares cursor address space
// - Base address offsets refresh address, 14-bit
// - Synchronise pen strobe, latch refresh address
`default_nettype none
module crtp_register_port
	import crtp_pkg::*;
#(
	parameter int unsigned ADDR_W = CRTP_ADDR_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Processor bus
	input wire logic access_i,
	input wire logic read_i,
	input wire logic port_select_line_i,
	input wire logic [7:0] wdata_i,
	output var logic [7:0] rdata_o,
	// Raster side
	input wire logic [ADDR_W-1:0] linear_count_i,
	input wire logic active_video_flag_i,
	input wire logic pen_capture_strobe_i,
	output var logic [ADDR_W-1:0] refresh_addr_out_o,
	output var logic cursor_marker_out_o,
	output var logic pen_flag_o,
	// Timing registers to the raster counters
	output var logic [CRTP_NUM_TIMING-1:0][7:0] timing_regs_o
);
	if (ADDR_W < 9 || ADDR_W > 16) begin : g_bad_addr_w
		$error("ADDR_W must lie in 9..16");
	end

	// ---------------------------------------------
	// Helpers
	// ---------------------------------------------
	function automatic logic [ADDR_W-1:0] join_addr(input crtp_byte_t hi, input crtp_byte_t lo);
		logic [15:0] full;
		full = {hi, lo};
		return full[ADDR_W-1:0];
	endfunction

	function automatic crtp_byte_t high_byte(input logic [ADDR_W-1:0] value);
		logic [15:0] full;
		full = 16'(value);
		return full[15:8];
	endfunction

	// ---------------------------------------------
	// State
	// ---------------------------------------------
	crtp_byte_t regs [CRTP_NUM_CTRL];
	logic [CRTP_IDX_W-1:0] index_pointer;
	logic [ADDR_W-1:0] next_refresh_addr;

	crtp_pen_if #(.ADDR_W(ADDR_W)) pen ();

	crtp_pen_capture #(.ADDR_W(ADDR_W)) u_pen (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.pen_capture_strobe_i(pen_capture_strobe_i),
		.pen(pen.capture)
	);

	// ---------------------------------------------
	// Decode
	// ---------------------------------------------
	wire index_write = access_i && !read_i && !port_select_line_i;
	wire data_access = access_i && port_select_line_i;
	wire index_valid = index_pointer < CRTP_IDX_LIMIT;
	wire ctrl_hit = index_pointer < CRTP_IDX_PEN_HI;
	wire data_write = data_access && !read_i && ctrl_hit;
	wire data_read = data_access && read_i;
	wire [3:0] ctrl_sel = index_pointer[3:0];
	wire [ADDR_W-1:0] start_addr = join_addr(regs[CRTP_IDX_START_HI[3:0]], regs[CRTP_IDX_START_LO[3:0]]);
	wire [ADDR_W-1:0] cursor_addr = join_addr(regs[CRTP_IDX_CURSOR_HI[3:0]], regs[CRTP_IDX_CURSOR_LO[3:0]]);
	wire [7:0] pen_hi = high_byte(pen.pen_addr);
	wire [7:0] pen_lo = pen.pen_addr[7:0];
	wire [7:0] ctrl_value = regs[ctrl_sel];
	wire [7:0] read_value = !index_valid ? 8'h00 :
		(index_pointer == CRTP_IDX_PEN_HI) ? pen_hi :
		(index_pointer == CRTP_IDX_PEN_LO) ? pen_lo : ctrl_value;

	assign next_refresh_addr = ADDR_W'(linear_count_i + start_addr);
	assign pen.refresh_addr = refresh_addr_out_o;
	assign pen.pen_read = data_read && (index_pointer == CRTP_IDX_PEN_LO);
	assign pen_flag_o = pen.pen_flag;

	// ---------------------------------------------
	// Index register
	// ---------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			index_pointer <= CRTP_IDX_RST;
		end else if (index_write) begin
			index_pointer <= wdata_i[CRTP_IDX_W-1:0];
		end
	end

	// ---------------------------------------------
	// Control registers
	// ---------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			for (int i = 0; i < CRTP_NUM_CTRL; i++) begin
				regs[i] <= CRTP_REG_RST;
			end
		end else if (data_write) begin
			regs[ctrl_sel] <= wdata_i;
		end
	end

	for (genvar g = 0; g < CRTP_NUM_TIMING; g++) begin : g_timing
		assign timing_regs_o[g] = regs[g];
	end

	// ---------------------------------------------
	// Read data
	// ---------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_o <= CRTP_RDATA_RST;
		end else if (data_read) begin
			rdata_o <= read_value;
		end else if (access_i && read_i) begin
			rdata_o <= CRTP_RDATA_RST;
		end
	end

	// ---------------------------------------------
	// Refresh address and cursor
	// ---------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			refresh_addr_out_o <= '0;
			cursor_marker_out_o <= 1'b0;
		end else begin
			refresh_addr_out_o <= next_refresh_addr;
			cursor_marker_out_o <= active_video_flag_i && (next_refresh_addr == cursor_addr);
		end
	end

	// ---------------------------------------------
	// Checks
	// ---------------------------------------------
	AST_INDEX_LOAD: assert property (@(posedge clk_i) disable iff (reset_i)
		index_write |=> index_pointer == $past(wdata_i[CRTP_IDX_W-1:0]))
		else $error("index not loaded on select-low write");

	AST_INDEX_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
		!index_write |=> $stable(index_pointer))
		else $error("index changed without index write");

	AST_DATA_WRITE: assert property (@(posedge clk_i) disable iff (reset_i)
		data_write |=> regs[$past(ctrl_sel)] == $past(wdata_i))
		else $error("selected register not written");

	AST_BASE_ANY: assert property (@(posedge clk_i) disable iff (reset_i)
		(data_write && ctrl_sel == CRTP_IDX_START_LO[3:0]) |=> start_addr[7:0] == $past(wdata_i))
		else $error("base address low byte not taken as written");

	AST_OOR_READ: assert property (@(posedge clk_i) disable iff (reset_i)
		(data_read && !index_valid) |=> rdata_o == 8'h00)
		else $error("out of range read not zero");

	AST_OOR_WRITE: assert property (@(posedge clk_i) disable iff (reset_i)
		(data_access && !read_i && !ctrl_hit) |=> $stable(start_addr) && $stable(cursor_addr))
		else $error("write beyond control registers changed state");

	AST_OFFSET: assert property (@(posedge clk_i) disable iff (reset_i)
		1'b1 |=> refresh_addr_out_o == ADDR_W'($past(linear_count_i) + $past(start_addr)))
		else $error("refresh address not offset by base");

	AST_CURSOR: assert property (@(posedge clk_i) disable iff (reset_i)
		cursor_marker_out_o |-> (refresh_addr_out_o == $past(cursor_addr)) && $past(active_video_flag_i))
		else $error("cursor marker without address match");

	AST_PEN_READ: assert property (@(posedge clk_i) disable iff (reset_i)
		(data_read && index_pointer == CRTP_IDX_PEN_LO) |=> rdata_o == $past(pen.pen_addr[7:0]))
		else $error("pen low byte read wrong");

	sequence s_index_then_read;
		(index_write && wdata_i[CRTP_IDX_W-1:0] < CRTP_IDX_PEN_HI) ##1 data_read;
	endsequence

	sequence s_index_then_write;
		(index_write && wdata_i[CRTP_IDX_W-1:0] < CRTP_IDX_PEN_HI) ##1 data_write;
	endsequence

	property p_pair_read;
		@(posedge clk_i) disable iff (reset_i)
		s_index_then_read |=> rdata_o == regs[$past(wdata_i[3:0], 2)];
	endproperty

	AST_PAIR_READ: assert property (p_pair_read)
		else $error("paired read did not return selected register");

	AST_PAIR_WRITE: assert property (@(posedge clk_i) disable iff (reset_i)
		s_index_then_write |=> regs[$past(wdata_i[3:0], 2)] == $past(wdata_i))
		else $error("paired write did not reach selected register");

	AST_INDEX_READ_ZERO: assert property (@(posedge clk_i) disable iff (reset_i)
		(access_i && read_i && !port_select_line_i) |=> rdata_o == 8'h00)
		else $error("index register read not zero");

	AST_RDATA_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
		!(access_i && read_i) |=> $stable(rdata_o))
		else $error("read data changed without read access");

	AST_PEN_HI_READ: assert property (@(posedge clk_i) disable iff (reset_i)
		(data_read && index_pointer == CRTP_IDX_PEN_HI) |=> rdata_o == $past(pen_hi))
		else $error("pen high byte read wrong");

	AST_CURSOR_MATCH: assert property (@(posedge clk_i) disable iff (reset_i)
		(active_video_flag_i && ADDR_W'(linear_count_i + start_addr) == cursor_addr) |=> cursor_marker_out_o)
		else $error("cursor marker missing on address match");

	AST_NO_MARK_BLANK: assert property (@(posedge clk_i) disable iff (reset_i)
		!active_video_flag_i |=> !cursor_marker_out_o)
		else $error("cursor marker outside displayed area");
endmodule
`default_nettype wire

// ===== tb/crtp_host_model.sv
// Processor bus model driving the register port
`default_nettype none
module crtp_host_model (
	// Clock
	input wire logic clk_i,
	// Bus
	output logic access_o,
	output logic read_o,
	output logic sel_o,
	output logic [7:0] wdata_o,
	input wire logic [7:0] rdata_i
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		access_o = 1'b0;
		read_o = 1'b0;
		sel_o = 1'b0;
		wdata_o = 8'h00;
	end
	// One access, taken at the next edge
	task automatic op(input logic s, input logic r, input logic [7:0] d, output logic [7:0] q);
		access_o = 1'b1;
		read_o = r;
		sel_o = s;
		wdata_o = r ? ~wdata_o : d;
		@(posedge clk_i);
		#1;
		q = rdata_i;
	endtask
	// Index write, then data access
	task automatic reg_op(input logic [4:0] i, input logic r, input logic [7:0] d, output logic [7:0] q);
		op(1'b0, 1'b0, {3'h0, i}, q);
		op(1'b1, r, d, q);
	endtask
	task automatic idle();
		access_o = 1'b0;
		@(posedge clk_i);
		#1;
	endtask
endmodule
`default_nettype wire

// ===== tb/crt_timing_indexed_register_port_bench.sv
// Self-checking bench for the register port
`default_nettype none
module crt_timing_indexed_register_port_bench
	import crtp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic stb = 1'b0;
	logic act = 1'b0;
	logic access, rd, sel, mark, flag;
	logic [7:0] wd, rdata, q;
	logic [13:0] lin = 14'h0000;
	logic [13:0] ra, p;
	logic [CRTP_NUM_TIMING-1:0][7:0] tim;
	logic [7:0] er [0:15];
	logic [31:0] seed = 32'hcab9_a53d;
	int n_fail = 0;
	int total_checks = 0;
	always #5 clk = ~clk;
	crtp_register_port i_dut (.clk_i(clk), .reset_i(reset), .access_i(access), .read_i(rd),
		.port_select_line_i(sel), .wdata_i(wd), .rdata_o(rdata), .linear_count_i(lin),
		.active_video_flag_i(act), .pen_capture_strobe_i(stb), .refresh_addr_out_o(ra),
		.cursor_marker_out_o(mark), .pen_flag_o(flag), .timing_regs_o(tim));
	crtp_host_model i_host (.clk_i(clk), .access_o(access), .read_o(rd), .sel_o(sel), .wdata_o(wd),
		.rdata_i(rdata));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	function automatic logic [13:0] base();
		return {er[12][5:0], er[13]};
	endfunction
	task automatic check(input logic [13:0] seen, input logic [13:0] want);
		total_checks++;
		if (seen !== want) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic test_done();
		if (n_fail == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic wr(input logic [4:0] i, input logic [7:0] d);
		i_host.reg_op(i, 1'b0, d, q);
		if (i < 5'h10) er[i[3:0]] = d;
	endtask
	task automatic rdc(input logic [4:0] i, input logic [7:0] w);
		i_host.reg_op(i, 1'b1, 8'h00, q);
		check(14'(q), 14'(w));
	endtask
	task automatic pair(input logic [4:0] i, input logic [13:0] v);
		wr(i, {2'b00, v[13:8]});
		wr(i + 5'h01, v[7:0]);
	endtask
	task automatic verify();
		for (int i = 0; i < 16; i++) rdc(i[4:0], er[i]);
		i_host.idle();
		for (int i = 0; i < 12; i++) check(14'(tim[i]), 14'(er[i]));
	endtask
	initial begin
		#50000;
		n_fail++;
		test_done();
	end
	initial begin
		repeat (5) @(posedge clk);
		#1;
		reset = 1'b0;
		rdc(5'h0F, 8'h00);
		for (int i = 0; i < 16; i++) begin
			seed = xs(seed);
			wr(i[4:0], (i == 12 || i == 14) ? {2'b00, seed[5:0]} : seed[7:0]);
		end
		verify();
		i_host.op(1'b1, 1'b1, 8'h00, q);
		check(14'(q), 14'(er[15]));
		i_host.op(1'b0, 1'b1, 8'h00, q);
		check(14'(q), 14'h0000);
		i_host.op(1'b0, 1'b0, 8'he3, q);
		i_host.op(1'b1, 1'b1, 8'h00, q);
		check(14'(q), 14'(er[3]));
		for (int k = 0; k < 4; k++) wr(5'h10 + k[4:0], seed[7:0] ^ 8'h5a);
		wr(5'h1F, 8'hff);
		for (int i = 16; i < 20; i++) rdc(i[4:0], 8'h00);
		verify();
		for (int n = 0; n < 6; n++) begin
			seed = xs(seed);
			pair(5'h0C, n == 0 ? 14'h3fff : seed[13:0]);
			i_host.idle();
			lin = n == 0 ? 14'h0001 : seed[29:16];
			repeat (2) @(posedge clk);
			#1;
			check(ra, lin + base());
		end
		stb = 1'b1;
		p = lin + base();
		repeat (4) @(posedge clk);
		#1;
		stb = 1'b0;
		check(14'(flag), 14'h0001);
		rdc(5'h10, {2'b00, p[13:8]});
		rdc(5'h11, p[7:0]);
		i_host.idle();
		check(14'(flag), 14'h0000);
		act = 1'b1;
		pair(5'h0E, p);
		i_host.idle();
		repeat (2) @(posedge clk);
		#1;
		check(14'(mark), 14'h0001);
		pair(5'h0C, base() + 14'(er[1]));
		pair(5'h0E, p + 14'(er[1]));
		i_host.idle();
		lin = lin - 14'(er[1]) + 14'(er[1]);
		repeat (2) @(posedge clk);
		#1;
		check(14'(mark), 14'h0001);
		act = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check(14'(mark), 14'h0000);
		test_done();
	end
endmodule
`default_nettype wire
